// ===== swrb_device.sv
// Sensor core register bank with frame-synchronized window registers
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module swrb_device
  import swrb_pkg::*;
#(
  parameter logic [15:0] IDENT_VALUE = 16'h0a5a // Arbitrary identity value
) (
  input wire logic core_clk,
  input wire logic nrst,
  swrb_link_if.device link,
  input wire logic first_dark_row,
  input wire logic integ_mismatch,
  input wire logic dual_adc,
  input wire logic [13:0] hblank_ctx_a,
  output logic [10:0] row_start,
  output logic [10:0] column_start,
  output logic [10:0] row_count,
  output logic [10:0] column_count,
  output logic [13:0] row_lead_blank,
  output logic context_sel,
  output logic bad_frame,
  output logic frame_suppress,
  output logic [15:0] global_shutter_control
);
  logic [15:0] pend [1:5];
  logic [15:0] act [1:5];
  logic [5:1] dirty;
  logic [15:0] misc [0:MISC_COUNT-1];
  logic [15:0] page_select;
  logic [15:0] bytewise_address;
  logic [15:0] context_select;
  logic [15:0] reset_control;
  logic integ_seen;
  logic ack_q;
  logic [15:0] rdata_q;

  logic wr_en;
  logic core_sel;
  logic frame_hit;
  logic [3:0] slot;
  logic apply;
  logic ym_apply;
  logic next_ctx;
  logic [15:0] next_hblank_alt;
  logic [15:0] rd_value;

  always_comb begin
    wr_en = link.req & link.we;
    // Only the core page is local; other pages read zero and drop writes, except page select and bytewise address
    core_sel = (page_select == CORE_PAGE);
    frame_hit = core_sel && (link.addr >= ROW_START_ADDR) && (link.addr <= HBLANK_ALT_ADDR);
    slot = core_sel ? misc_slot(link.addr) : MISC_NONE;
    // Hold bit keeps pending values from applying, so a group of edits lands together
    apply = first_dark_row & ~reset_control[SYNC_HOLD_BIT];
    ym_apply = apply & (|dirty);
  end

  // Window registers stage writes here until frame start
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 1; i <= 5; i++) begin
        pend[i] <= FRAME_RESET[i];
      end
    end else if (wr_en && frame_hit) begin
      for (int i = 1; i <= 5; i++) begin
        if (link.addr[2:0] == 3'(i)) begin
          pend[i] <= link.wdata & FRAME_MASK[i];
        end
      end
    end
  end

  // A write in the frame-start cycle stays pending for the next frame
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dirty <= 5'h00;
    end else begin
      for (int i = 1; i <= 5; i++) begin
        dirty[i] <= (wr_en && frame_hit && link.addr[2:0] == 3'(i)) | (dirty[i] & ~apply);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 1; i <= 5; i++) begin
        act[i] <= FRAME_RESET[i];
      end
    end else if (apply) begin
      for (int i = 1; i <= 5; i++) begin
        if (dirty[i]) begin
          act[i] <= window_floor(i, pend[i], dual_adc);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MISC_COUNT; i++) begin
        misc[i] <= MISC_RESET[i];
      end
    end else if (wr_en && slot != MISC_NONE) begin
      misc[slot] <= link.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      page_select <= PAGE_RESET;
      bytewise_address <= BYTEWISE_RESET;
    end else if (wr_en) begin
      if (link.addr == PAGE_SELECT_ADDR) begin
        page_select <= link.wdata;
      end
      if (link.addr == BYTEWISE_ADDR) begin
        bytewise_address <= link.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      context_select <= CONTEXT_RESET;
      reset_control <= RESET_CONTROL_RESET;
    end else if (wr_en && core_sel) begin
      if (link.addr == CONTEXT_SELECT_ADDR) begin
        context_select <= link.wdata & CONTEXT_MASK;
      end
      if (link.addr == RESET_CONTROL_ADDR) begin
        reset_control <= link.wdata & RESET_CONTROL_MASK;
      end
    end
  end

  // Mismatch events collect over a frame; set beats the frame-start clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      integ_seen <= 1'b0;
    end else if (integ_mismatch) begin
      integ_seen <= 1'b1;
    end else if (first_dark_row) begin
      integ_seen <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bad_frame <= 1'b0;
      frame_suppress <= 1'b0;
    end else if (first_dark_row) begin
      bad_frame <= ym_apply | integ_seen | integ_mismatch;
      frame_suppress <= (ym_apply | integ_seen | integ_mismatch) &
                        ~reset_control[BAD_FRAME_DISPLAY_BIT];
    end
  end

  // Look ahead at this cycle's write so blanking follows with no extra lag
  always_comb begin
    next_ctx = context_select[CONTEXT_SELECT_BIT];
    if (wr_en && core_sel && link.addr == CONTEXT_SELECT_ADDR) begin
      next_ctx = link.wdata[CONTEXT_SELECT_BIT];
    end
    next_hblank_alt = act[HBLANK_ALT_SLOT];
    if (apply && dirty[HBLANK_ALT_SLOT]) begin
      next_hblank_alt = pend[HBLANK_ALT_SLOT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      row_lead_blank <= FRAME_RESET[HBLANK_ALT_SLOT][13:0];
    end else begin
      row_lead_blank <= next_ctx ? next_hblank_alt[13:0] : hblank_ctx_a;
    end
  end

  // Window reads return the last written value after masking, even while still pending
  always_comb begin
    rd_value = 16'h0000;
    if (link.addr == PAGE_SELECT_ADDR) begin
      rd_value = page_select;
    end else if (link.addr == BYTEWISE_ADDR) begin
      rd_value = bytewise_address;
    end else if (core_sel) begin
      if (link.addr == IDENT_ADDR || link.addr == MIRROR_ADDR) begin
        rd_value = IDENT_VALUE;
      end else if (frame_hit) begin
        rd_value = pend[link.addr[2:0]];
      end else if (link.addr == RESET_CONTROL_ADDR) begin
        rd_value = reset_control;
      end else if (link.addr == CONTEXT_SELECT_ADDR) begin
        rd_value = context_select;
      end else if (slot != MISC_NONE) begin
        rd_value = misc[slot];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= link.req;
      rdata_q <= rd_value;
    end
  end

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign row_start = act[1][10:0];
  assign column_start = act[2][10:0];
  assign row_count = act[ROW_COUNT_SLOT][10:0];
  assign column_count = act[COLUMN_COUNT_SLOT][10:0];
  assign context_sel = context_select[CONTEXT_SELECT_BIT];
  assign global_shutter_control = misc[1];
endmodule

// ===== swrb_host.sv
// Controller that issues register accesses to the sensor register bank
`timescale 1ns/1ps
module swrb_host
  import swrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  swrb_link_if.host link,
  input wire logic [2:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata
);
  swrb_state_type state;
  logic [7:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic dual_cfg;
  logic done;
  logic warn;
  logic [15:0] rd_result;
  logic [15:0] cur_page;
  logic req_q;
  logic we_q;
  logic [7:0] addr_q;
  logic [15:0] wdata_q;
  logic go_wr;
  logic go_rd;
  logic low_start;
  logic [15:0] safe_wdata;
  logic dual_now;

  always_comb begin
    go_wr = sw_wr && sw_addr == HOST_CTRL_REG && sw_wdata[CTRL_WRITE_BIT] && state == SWRB_IDLE;
    go_rd = sw_wr && sw_addr == HOST_CTRL_REG && sw_wdata[CTRL_READ_BIT] &&
            !sw_wdata[CTRL_WRITE_BIT] && state == SWRB_IDLE;
    low_start = cur_page == CORE_PAGE &&
                ((cmd_addr == ROW_START_ADDR && cmd_wdata[10:0] < ROW_START_ADVISED) ||
                 (cmd_addr == COLUMN_START_ADDR && cmd_wdata[10:0] < COLUMN_START_ADVISED));
    // Dual bit sent with the go command must already set the floor
    dual_now = dual_cfg;
    if (sw_wr && sw_addr == HOST_CTRL_REG) begin
      dual_now = sw_wdata[CTRL_DUAL_BIT];
    end
    safe_wdata = cmd_wdata;
    if (cur_page == CORE_PAGE && cmd_addr == ROW_COUNT_ADDR) begin
      safe_wdata = window_floor(ROW_COUNT_SLOT, cmd_wdata, dual_now);
    end else if (cur_page == CORE_PAGE && cmd_addr == COLUMN_COUNT_ADDR) begin
      safe_wdata = window_floor(COLUMN_COUNT_SLOT, cmd_wdata, dual_now);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_addr <= 8'h00;
      cmd_wdata <= 16'h0000;
      dual_cfg <= 1'b0;
    end else if (sw_wr) begin
      if (sw_addr == HOST_ADDR_REG) begin
        cmd_addr <= sw_wdata[7:0];
      end
      if (sw_addr == HOST_WDATA_REG) begin
        cmd_wdata <= sw_wdata;
      end
      if (sw_addr == HOST_CTRL_REG) begin
        dual_cfg <= sw_wdata[CTRL_DUAL_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= SWRB_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 16'h0000;
    end else begin
      req_q <= 1'b0;
      case (state)
        SWRB_IDLE: begin
          if (go_wr || go_rd) begin
            req_q <= 1'b1;
            we_q <= go_wr;
            addr_q <= cmd_addr;
            wdata_q <= safe_wdata;
            state <= SWRB_ISSUE;
          end
        end
        SWRB_ISSUE: state <= SWRB_WAIT;
        SWRB_WAIT: begin
          if (link.ack) begin
            state <= SWRB_IDLE;
          end
        end
        default: state <= SWRB_IDLE;
      endcase
    end
  end

  // Page shadow keeps the floors applied only to core-page writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cur_page <= PAGE_RESET;
      rd_result <= 16'h0000;
    end else begin
      if (go_wr && cmd_addr == PAGE_SELECT_ADDR) begin
        cur_page <= cmd_wdata;
      end
      if (state == SWRB_WAIT && link.ack && !we_q) begin
        rd_result <= link.rdata;
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      warn <= 1'b0;
    end else begin
      if (state == SWRB_WAIT && link.ack) begin
        done <= 1'b1;
      end else if (sw_wr && sw_addr == HOST_STATUS_REG && sw_wdata[STAT_DONE_BIT]) begin
        done <= 1'b0;
      end
      if (go_wr && low_start) begin
        warn <= 1'b1;
      end else if (sw_wr && sw_addr == HOST_STATUS_REG && sw_wdata[STAT_WARN_BIT]) begin
        warn <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sw_rdata <= 16'h0000;
    end else if (sw_rd) begin
      case (sw_addr)
        HOST_ADDR_REG: sw_rdata <= {8'h00, cmd_addr};
        HOST_WDATA_REG: sw_rdata <= cmd_wdata;
        HOST_CTRL_REG: sw_rdata <= {13'h0000, dual_cfg, 2'b00};
        HOST_STATUS_REG: sw_rdata <= {13'h0000, warn, done, state != SWRB_IDLE};
        HOST_RDATA_REG: sw_rdata <= rd_result;
        default: sw_rdata <= 16'h0000;
      endcase
    end else begin
      sw_rdata <= 16'h0000;
    end
  end

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
endmodule

// ===== swrb_link_if.sv
// Register link between the controller and the sensor register bank
`timescale 1ns/1ps
interface swrb_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport device (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata
  );
  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata
  );
endinterface

// ===== swrb_link_sva.sv
// Link checker for the register bank and its controller
`timescale 1ns/1ps
module swrb_link_sva #(
  parameter logic [15:0] IDENT_VALUE = 16'h0a5a // Arbitrary identity value
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  logic [15:0] page;
  logic [15:0] shutter;
  logic [10:0] row_first;
  logic rd0;
  logic wr0;
  // Shadows of what accepted writes should leave behind
  assign rd0 = req && !we && page == 16'h0000;
  assign wr0 = req && we && page == 16'h0000;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      page <= 16'h0000;
    end else if (req && we && addr == 8'hf0) begin
      page <= wdata;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shutter <= 16'h0000;
    end else if (wr0 && addr == 8'hc0) begin
      shutter <= wdata;
    end
  end
  // Window readback shows the pending value, not the applied one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      row_first <= 11'h01c;
    end else if (wr0 && addr == 8'h01) begin
      row_first <= wdata[10:0];
    end
  end
  a_ack_after_req: assert property (req |=> ack)
    else $error("link request not answered next cycle");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("link answer without request");
  a_ident_read: assert property (rd0 && (addr == 8'h00 || addr == 8'hff)
    |=> rdata == IDENT_VALUE) else $error("reserved word read wrong");
  a_page_global: assert property (req && !we && addr == 8'hf0 |=> rdata == page)
    else $error("page register readback wrong");
  a_other_page: assert property (req && !we && page != 16'h0000 && addr == 8'h01
    |=> rdata == 16'h0000) else $error("core register seen on other page");
  a_shutter_now: assert property (rd0 && addr == 8'hc0 |=> rdata == shutter)
    else $error("immediate register readback wrong");
  a_row_pending: assert property (rd0 && addr == 8'h01
    |=> rdata == {5'h00, row_first}) else $error("pending row start readback wrong");
  a_count_floor: assert property (rd0 && addr == 8'h03
    |=> rdata[15:11] == 5'h00 && rdata[10:0] >= 11'd2) else $error("row count below floor");
  a_unmapped_zero: assert property (rd0 && addr == 8'h10 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule

// ===== swrb_pkg.sv
// Shared constants for the sensor window register bank and its controller
package swrb_pkg;
  localparam logic [7:0] IDENT_ADDR = 8'h00;
  localparam logic [7:0] ROW_START_ADDR = 8'h01;
  localparam logic [7:0] COLUMN_START_ADDR = 8'h02;
  localparam logic [7:0] ROW_COUNT_ADDR = 8'h03;
  localparam logic [7:0] COLUMN_COUNT_ADDR = 8'h04;
  localparam logic [7:0] HBLANK_ALT_ADDR = 8'h05;
  localparam logic [7:0] RESET_CONTROL_ADDR = 8'h0d;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'hf0;
  localparam logic [7:0] BYTEWISE_ADDR = 8'hf1;
  localparam logic [7:0] CONTEXT_SELECT_ADDR = 8'hf2;
  localparam logic [7:0] MIRROR_ADDR = 8'hff;
  localparam logic [15:0] CORE_PAGE = 16'h0000;

  // Frame-synchronized window registers, slots 1 to 5
  localparam logic [15:0] FRAME_RESET [1:5] = '{16'h001c, 16'h003c, 16'h04b0, 16'h0640, 16'h015c};
  localparam logic [15:0] FRAME_MASK [1:5] = '{16'h07ff, 16'h07ff, 16'h07ff, 16'h07ff, 16'h3fff};
  localparam int ROW_COUNT_SLOT = 3;
  localparam int COLUMN_COUNT_SLOT = 4;
  localparam int HBLANK_ALT_SLOT = 5;

  // Immediate registers: pll, shutter/strobe/flash timing, external sampling
  localparam int MISC_COUNT = 12;
  localparam logic [3:0] MISC_NONE = 4'hf;
  localparam logic [15:0] MISC_RESET [0:11] = '{16'h0501, 16'h0000, 16'h0064, 16'h0064,
    16'h0096, 16'h00c8, 16'h0064, 16'h0078, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [7:0] MISC_ADDR [0:11] = '{8'h67, 8'hc0, 8'hc1, 8'hc2,
    8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'he0, 8'he1, 8'he2, 8'he3};

  localparam logic [15:0] PAGE_RESET = 16'h0000;
  localparam logic [15:0] BYTEWISE_RESET = 16'h0000;
  localparam logic [15:0] CONTEXT_RESET = 16'h000b;
  localparam logic [15:0] CONTEXT_MASK = 16'hffff;
  localparam logic [15:0] RESET_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] RESET_CONTROL_MASK = 16'h8100;
  localparam int CONTEXT_SELECT_BIT = 0;
  localparam int BAD_FRAME_DISPLAY_BIT = 8;
  localparam int SYNC_HOLD_BIT = 15;

  localparam logic [10:0] ROW_START_ADVISED = 11'd20;
  localparam logic [10:0] COLUMN_START_ADVISED = 11'd52;
  localparam logic [15:0] ROW_COUNT_MIN = 16'd2;
  localparam logic [15:0] COLUMN_COUNT_MIN_SINGLE = 16'd9;
  localparam logic [15:0] COLUMN_COUNT_MIN_DUAL = 16'd17;
  localparam int FRAME_START_LEAD_ROWS = 8;

  // Controller software registers
  localparam logic [2:0] HOST_ADDR_REG = 3'h0;
  localparam logic [2:0] HOST_WDATA_REG = 3'h1;
  localparam logic [2:0] HOST_CTRL_REG = 3'h2;
  localparam logic [2:0] HOST_STATUS_REG = 3'h3;
  localparam logic [2:0] HOST_RDATA_REG = 3'h4;
  localparam int CTRL_WRITE_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_DUAL_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_WARN_BIT = 2;

  typedef enum logic [1:0] {
    SWRB_IDLE = 2'b00,
    SWRB_ISSUE = 2'b01,
    SWRB_WAIT = 2'b10
  } swrb_state_type;

  function automatic logic [3:0] misc_slot(input logic [7:0] a);
    misc_slot = MISC_NONE;
    for (int i = 0; i < MISC_COUNT; i++) begin
      if (a == MISC_ADDR[i]) begin
        misc_slot = 4'(i);
      end
    end
  endfunction

  function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] m);
    clamp_min = (v < m) ? m : v;
  endfunction

  // Lowest legal count for a window slot; other slots pass unchanged
  function automatic logic [15:0] window_floor(input int slot, input logic [15:0] v,
                                               input logic dual);
    if (slot == ROW_COUNT_SLOT) begin
      window_floor = clamp_min(v, ROW_COUNT_MIN);
    end else if (slot == COLUMN_COUNT_SLOT) begin
      window_floor = clamp_min(v, dual ? COLUMN_COUNT_MIN_DUAL : COLUMN_COUNT_MIN_SINGLE);
    end else begin
      window_floor = v;
    end
  endfunction
endpackage

// ===== tb_top.sv
// Self-checking bench for the register bank and its controller
`timescale 1ns/1ps
module tb_top
  import swrb_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] sw_addr = 3'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic first_dark_row = 1'b0;
  logic integ_mismatch = 1'b0;
  logic dual_adc = 1'b0;
  logic [13:0] hblank_ctx_a = 14'h0123;
  logic [10:0] row_start, column_start, row_count, column_count;
  logic [13:0] row_lead_blank;
  logic context_sel, bad_frame, frame_suppress;
  logic [15:0] global_shutter_control;
  int bad_count = 0;
  int tests_run = 0;
  always #50 core_clk = ~core_clk;
  swrb_link_if link ();
  swrb_device #(.IDENT_VALUE(16'h0a5a)) u_swrb_device (.core_clk(core_clk), .nrst(nrst),
    .link(link), .first_dark_row(first_dark_row), .integ_mismatch(integ_mismatch),
    .dual_adc(dual_adc), .hblank_ctx_a(hblank_ctx_a), .row_start(row_start),
    .column_start(column_start), .row_count(row_count), .column_count(column_count),
    .row_lead_blank(row_lead_blank), .context_sel(context_sel), .bad_frame(bad_frame),
    .frame_suppress(frame_suppress), .global_shutter_control(global_shutter_control));
  swrb_host u_swrb_host (.core_clk(core_clk), .nrst(nrst), .link(link), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  swrb_link_sva #(.IDENT_VALUE(16'h0a5a)) u_swrb_link_sva (.core_clk(core_clk), .nrst(nrst),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  // One access through the controller, waiting for done under a bound
  task automatic dev_access(input logic w, input logic [7:0] a, input logic [15:0] d,
                            output logic [15:0] q);
    logic [15:0] st;
    int n;
    sw_write(HOST_ADDR_REG, {8'h00, a});
    sw_write(HOST_WDATA_REG, d);
    sw_write(HOST_CTRL_REG, {13'h0000, dual_adc, ~w, w});
    n = 0;
    st = 16'h0000;
    while (st[STAT_DONE_BIT] !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        give_verdict();
      end
      sw_read(HOST_STATUS_REG, st);
    end
    sw_write(HOST_STATUS_REG, 16'h0002);
    sw_read(HOST_RDATA_REG, q);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    dev_access(1'b1, a, d, q);
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [15:0] want);
    logic [15:0] q;
    dev_access(1'b0, a, 16'h0000, q);
    check(q, want);
  endtask
  task automatic frame(input logic mis);
    @(posedge core_clk);
    first_dark_row <= 1'b1;
    integ_mismatch <= mis;
    @(posedge core_clk);
    first_dark_row <= 1'b0;
    integ_mismatch <= 1'b0;
    #1;
  endtask
  task automatic t_defaults();
    logic [7:0] ma [12] = '{8'h67, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6,
                           8'he0, 8'he1, 8'he2, 8'he3};
    check({5'h00, row_count}, 16'h04b0);
    check({2'h0, row_lead_blank}, 16'h015c);
    check({15'h0000, context_sel}, 16'h0001);
    for (int i = 0; i < 12; i++) reg_chk(ma[i], MISC_RESET[i]);
    for (int i = 1; i < 6; i++) reg_chk(i[7:0], FRAME_RESET[i]);
    reg_chk(8'hf2, 16'h000b);
    reg_chk(8'hff, 16'h0a5a);
  endtask
  task automatic t_immediate();
    reg_wr(8'hc0, 16'h1234);
    check(global_shutter_control, 16'h1234);
    reg_wr(8'h00, 16'hffff);
    reg_chk(8'h00, 16'h0a5a);
    reg_chk(8'h10, 16'h0000);
  endtask
  task automatic t_sync();
    reg_wr(8'h01, 16'h0030);
    check({5'h00, row_start}, 16'h001c);
    reg_chk(8'h01, 16'h0030);
    frame(1'b0);
    check({5'h00, row_start}, 16'h0030);
    reg_wr(8'h0d, 16'h8000);
    reg_wr(8'h02, 16'h0040);
    frame(1'b0);
    check({5'h00, column_start}, 16'h003c);
    reg_wr(8'h0d, 16'h0000);
    frame(1'b0);
    check({5'h00, column_start}, 16'h0040);
  endtask
  task automatic t_floor();
    reg_wr(8'h03, 16'h0000);
    reg_wr(8'h04, 16'h0001);
    frame(1'b0);
    check({5'h00, row_count}, 16'h0002);
    check({5'h00, column_count}, 16'h0009);
    reg_chk(8'h03, 16'h0002);
    @(posedge core_clk);
    dual_adc <= 1'b1;
    reg_wr(8'h04, 16'h0003);
    frame(1'b0);
    check({5'h00, column_count}, 16'h0011);
    reg_chk(8'h04, 16'h0011);
    @(posedge core_clk);
    dual_adc <= 1'b0;
  endtask
  // Advice thresholds checked at the exact boundary
  task automatic t_warn();
    logic [7:0] a [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
    logic [15:0] v [4] = '{16'h0013, 16'h0014, 16'h0033, 16'h0034};
    logic [15:0] st;
    for (int i = 0; i < 4; i++) begin
      reg_wr(a[i], v[i]);
      sw_read(HOST_STATUS_REG, st);
      check({15'h0000, st[STAT_WARN_BIT]}, {15'h0000, ~i[0]});
      sw_write(HOST_STATUS_REG, 16'h0004);
      reg_chk(a[i], v[i]);
    end
  endtask
  task automatic t_bad();
    // Mismatch on a frame-start cycle also marks the following frame
    logic [1:0] fl [6] = '{2'b11, 2'b00, 2'b11, 2'b10, 2'b10, 2'b00};
    for (int i = 0; i < 6; i++) begin
      if (i == 3) reg_wr(8'h0d, 16'h0100);
      frame(i == 2 || i == 3);
      check({14'h0000, bad_frame, frame_suppress}, {14'h0000, fl[i]});
    end
    reg_wr(8'h0d, 16'h0000);
  endtask
  task automatic t_context();
    reg_wr(8'h05, 16'h2abc);
    check({2'h0, row_lead_blank}, 16'h015c);
    frame(1'b0);
    check({2'h0, row_lead_blank}, 16'h2abc);
    reg_wr(8'hf2, 16'h0000);
    check({2'h0, row_lead_blank}, 16'h0123);
    check({15'h0000, context_sel}, 16'h0000);
    reg_wr(8'hf2, 16'h0001);
    check({2'h0, row_lead_blank}, 16'h2abc);
  endtask
  task automatic t_page();
    reg_wr(8'hf0, 16'h0001);
    reg_chk(8'hf0, 16'h0001);
    reg_chk(8'h01, 16'h0000);
    reg_wr(8'hc0, 16'h5555);
    reg_wr(8'hf1, 16'h0007);
    reg_wr(8'hf0, 16'h0000);
    reg_chk(8'hc0, 16'h1234);
    reg_chk(8'hf1, 16'h0007);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    t_defaults();
    t_immediate();
    t_sync();
    t_floor();
    t_warn();
    t_bad();
    t_context();
    t_page();
    give_verdict();
  end
endmodule
